// ==== common/bridge_cfg_pkg.sv ====
// package: register map, field layout, reset values and carrier types of the bridge window block
package bridge_cfg_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IO_LOW_IDX = 8'h1c;
  localparam logic [7:0] IO_HIGH_IDX = 8'h1d;
  localparam logic [7:0] DS_STATUS_IDX = 8'h1e;
  localparam logic [7:0] MEM_LOW_IDX = 8'h20;
  localparam logic [7:0] MEM_HIGH_IDX = 8'h22;
  localparam logic [7:0] BRIDGE_CTRL_IDX = 8'h3e;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h40;
  localparam int ADDR_W = 12;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int IO_CAP_BIT = 0;
  localparam int IO_ADDR_LSB = 4;
  localparam int MEM_ADDR_LSB = 4;
  localparam int MASTER_PARITY_BIT = 8;
  localparam int SYS_ERR_BIT = 14;
  localparam int POISON_BIT = 15;
  localparam int PARITY_EN_BIT = 0;
  localparam int SYS_ERR_EN_BIT = 1;
  localparam logic [15:0] STATUS_LIVE = 16'hc100;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic IO_CAP_RST = 1'h1;
  localparam logic [3:0] IO_LOW_RST = 4'hf;
  localparam logic [3:0] IO_HIGH_RST = 4'h0;
  localparam logic [11:0] MEM_LOW_RST = 12'hfff;
  localparam logic [11:0] MEM_HIGH_RST = 12'h000;
  localparam logic [1:0] BRIDGE_CTRL_RST = 2'h0;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } fwd_req_type;

  typedef struct packed {
    logic valid;
    logic forward;
  } fwd_resp_type;

  typedef struct packed {
    logic poisoned_cpl_rx;
    logic poisoned_wr_tx;
    logic err_msg_rx;
    logic poisoned_tlp_rx;
  } ds_event_type;

  typedef struct packed {
    logic [3:0] io_low;
    logic [3:0] io_high;
    logic [11:0] mem_low;
    logic [11:0] mem_high;
  } window_type;

endpackage

// ==== core/bridge_window_secondary_status.sv ====
// top: bridge window registers, downstream side status flags and apb slave
//
// Implementation choice: the APB interface to the registers.
module bridge_window_secondary_status (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bridge_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lock release for the width capability bit
  input wire logic cap_write_unlock,
  // downstream side events, one-cycle pulses
  input wire bridge_cfg_pkg::ds_event_type ds_event,
  // forwarding request and decision
  input wire bridge_cfg_pkg::fwd_req_type fwd_req,
  output bridge_cfg_pkg::fwd_resp_type fwd_resp,
  // interrupt
  output logic irq
);
  import bridge_cfg_pkg::*;

  // ****************************************************************
  // register state
  // ****************************************************************
  logic io_width_capability_q;
  logic [3:0] io_low_q;
  logic [3:0] io_high_q;
  logic [11:0] mem_low_q;
  logic [11:0] mem_high_q;
  logic [1:0] bridge_control_q;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // zero wait states: data and error are prepared in the setup cycle
  wire logic setup_ph = psel & ~penable;
  wire logic wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire logic sel_io_low = (paddr == byte_addr(IO_LOW_IDX));
  wire logic sel_io_high = (paddr == byte_addr(IO_HIGH_IDX));
  wire logic sel_status = (paddr == byte_addr(DS_STATUS_IDX));
  wire logic sel_mem_low = (paddr == byte_addr(MEM_LOW_IDX));
  wire logic sel_mem_high = (paddr == byte_addr(MEM_HIGH_IDX));
  wire logic sel_ctrl = (paddr == byte_addr(BRIDGE_CTRL_IDX));
  wire logic sel_mask = (paddr == byte_addr(IRQ_MASK_IDX));
  wire logic mapped = sel_io_low | sel_io_high | sel_status | sel_mem_low | sel_mem_high | sel_ctrl | sel_mask;
  wire logic lane0 = pstrb[0];
  wire logic lane1 = pstrb[1];

  // ****************************************************************
  // read views
  // ****************************************************************
  wire logic [7:0] io_low_view = {io_low_q, 3'h0, io_width_capability_q};
  wire logic [7:0] io_high_view = {io_high_q, 3'h0, io_width_capability_q};
  wire logic [15:0] mem_low_view = {mem_low_q, 4'h0};
  wire logic [15:0] mem_high_view = {mem_high_q, 4'h0};
  wire logic [15:0] status_view = status_q & STATUS_LIVE;
  wire logic [31:0] rd_mux =
    sel_io_low ? {24'h000000, io_low_view} :
    sel_io_high ? {24'h000000, io_high_view} :
    sel_status ? {16'h0000, status_view} :
    sel_mem_low ? {16'h0000, mem_low_view} :
    sel_mem_high ? {16'h0000, mem_high_view} :
    sel_ctrl ? {30'h00000000, bridge_control_q} :
    sel_mask ? {16'h0000, irq_mask_q} : 32'h00000000;

  // ****************************************************************
  // status flag set and clear
  // ****************************************************************
  wire logic parity_response_enable = bridge_control_q[PARITY_EN_BIT];
  wire logic system_error_enable = bridge_control_q[SYS_ERR_EN_BIT];
  wire logic set_master_parity = parity_response_enable &
                                 (ds_event.poisoned_cpl_rx | ds_event.poisoned_wr_tx);
  wire logic set_sys_err = system_error_enable & ds_event.err_msg_rx;
  wire logic set_poison = ds_event.poisoned_tlp_rx;
  wire logic [15:0] status_set = {set_poison, set_sys_err, 5'h00, set_master_parity, 8'h00};
  wire logic [15:0] wr_mask16 = {{8{lane1}}, {8{lane0}}};
  wire logic [15:0] status_clr = (wr_acc & sel_status) ? (pwdata[15:0] & wr_mask16 & STATUS_LIVE) : 16'h0000;

  // a clear never hides an event landing in the same cycle
  assign status_d = ((status_q & ~status_clr) | status_set) & STATUS_LIVE;

  // ****************************************************************
  // window and control registers
  // ****************************************************************
  // width bit is lockable: software may change it only while unlocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_width_capability_q <= IO_CAP_RST;
      io_low_q <= IO_LOW_RST;
      io_high_q <= IO_HIGH_RST;
    end else if (wr_acc && lane0) begin
      if (sel_io_low && cap_write_unlock) begin
        io_width_capability_q <= pwdata[IO_CAP_BIT];
      end
      if (sel_io_low) begin
        io_low_q <= pwdata[IO_ADDR_LSB +: 4];
      end
      if (sel_io_high) begin
        io_high_q <= pwdata[IO_ADDR_LSB +: 4];
      end
    end
  end

  // memory bounds span two lanes; each lane written only when strobed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_low_q <= MEM_LOW_RST;
      mem_high_q <= MEM_HIGH_RST;
    end else if (wr_acc) begin
      if (sel_mem_low && lane0) mem_low_q[3:0] <= pwdata[MEM_ADDR_LSB +: 4];
      if (sel_mem_low && lane1) mem_low_q[11:4] <= pwdata[15:8];
      if (sel_mem_high && lane0) mem_high_q[3:0] <= pwdata[MEM_ADDR_LSB +: 4];
      if (sel_mem_high && lane1) mem_high_q[11:4] <= pwdata[15:8];
    end
  end

  // bridge control enables and interrupt mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bridge_control_q <= BRIDGE_CTRL_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_acc) begin
      if (sel_ctrl && lane0) bridge_control_q <= pwdata[1:0];
      if (sel_mask && lane0) irq_mask_q[7:0] <= pwdata[7:0];
      if (sel_mask && lane1) irq_mask_q[15:8] <= pwdata[15:8];
    end
  end

  // sticky flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= status_d;
    end
  end

  // ****************************************************************
  // apb answer and interrupt
  // ****************************************************************
  // ready rises for the access cycle only, so each transfer completes at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h00000000;
      irq_q <= 1'h0;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      if (setup_ph) prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      irq_q <= |(status_d & irq_mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ****************************************************************
  // forwarding decision
  // ****************************************************************
  window_check u_window_check (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(fwd_req),
    .win('{io_low: io_low_q, io_high: io_high_q, mem_low: mem_low_q, mem_high: mem_high_q}),
    .resp(fwd_resp)
  );
endmodule // bridge_window_secondary_status

// ==== core/window_check.sv ====
// forwarding decision: compares a request address against the i/o and memory windows
module window_check (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request, bounds and decision
  input wire bridge_cfg_pkg::fwd_req_type req,
  input wire bridge_cfg_pkg::window_type win,
  output bridge_cfg_pkg::fwd_resp_type resp
);
  import bridge_cfg_pkg::*;

  // inclusive range test; base above limit gives no hit, so the window is empty
  function automatic logic in_range(input logic [11:0] val, input logic [11:0] lo, input logic [11:0] hi);
    in_range = (val >= lo) && (val <= hi) && (lo <= hi);
  endfunction

  // low address bits below the granule count as zero for base and ones for limit
  wire logic io_upper_zero = (req.addr[31:16] == 16'h0000);
  wire logic io_hit = io_upper_zero &&
                      in_range({8'h00, req.addr[15:12]}, {8'h00, win.io_low}, {8'h00, win.io_high});
  wire logic mem_hit = in_range(req.addr[31:20], win.mem_low, win.mem_high);
  wire logic hit_d = req.is_io ? io_hit : mem_hit;

  // decision registered so the top output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.forward <= req.valid & hit_d;
    end
  end
endmodule // window_check

// ==== dv/bridge_window_secondary_status_asserts.sv ====
// checker: apb, forwarding and interrupt relations at the block ports
module bridge_window_secondary_status_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bridge_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events, forwarding, interrupt
  input wire bridge_cfg_pkg::ds_event_type ds_event,
  input wire bridge_cfg_pkg::fwd_req_type fwd_req,
  input wire bridge_cfg_pkg::fwd_resp_type fwd_resp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import bridge_cfg_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // zero wait states, answer only after a setup cycle
  ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing after setup");
  ready_only_access_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  // fixed zero fields on reads
  status_zero_bits_a: assert property (pready && !pwrite && paddr == 12'h078 |-> prdata[13:9] == 5'h0 && prdata[7:0] == 8'h0)
    else $error("status zero bits set");
  io_high_rsvd_a: assert property (pready && !pwrite && paddr == 12'h074 |-> prdata[3:1] == 3'h0)
    else $error("io high reserved set");
  mem_low_rsvd_a: assert property (pready && !pwrite && paddr == 12'h080 |-> prdata[3:0] == 4'h0)
    else $error("mem low reserved set");
  // forwarding answers exactly one cycle later
  fwd_timing_a: assert property (fwd_req.valid |=> fwd_resp.valid)
    else $error("forward answer late");
  io_upper_miss_a: assert property (fwd_req.valid && fwd_req.is_io && fwd_req.addr[31:16] != 16'h0 |=> !fwd_resp.forward)
    else $error("io upper address forwarded");
  // interrupt rises only from an event or a register write
  irq_cause_a: assert property ($rose(irq) |-> $past(|ds_event) || $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("irq rose without cause");
  cover property (pready && pslverr);
  cover property (irq);
  cover property (fwd_resp.valid && fwd_resp.forward);
endmodule // bridge_window_secondary_status_asserts

// ==== dv/fwd_event_agent.sv ====
// partner: forwarding side, launches requests and event pulses on clock edges
module fwd_event_agent (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // commands from the bench
  input wire bridge_cfg_pkg::fwd_req_type cmd_req,
  input wire bridge_cfg_pkg::ds_event_type cmd_ev,
  // toward the block
  output bridge_cfg_pkg::fwd_req_type fwd_req,
  output bridge_cfg_pkg::ds_event_type ds_event
);
  timeunit 1ns;
  timeprecision 1ns;
  import bridge_cfg_pkg::*;
  // registered so each event changes on a clock edge and lasts as many cycles as its command
  always_ff @(posedge clk_sys) begin
    fwd_req <= rst ? '0 : cmd_req;
    ds_event <= rst ? '0 : cmd_ev;
  end
endmodule // fwd_event_agent

// ==== dv/tb.sv ====
// testbench: registers, events, interrupt and forwarding of the bridge window block
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bridge_cfg_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cap_write_unlock = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h595f9255;
  logic [3:0] pstrb = 4'h3, io_lo = 4'h2, io_hi = 4'h4;
  logic [11:0] m_lo = 12'h123, m_hi = 12'h124;
  logic pready, pslverr, irq, exp_f;
  fwd_req_type cmd_req = '0, fwd_req;
  ds_event_type cmd_ev = '0, ds_event;
  fwd_resp_type fwd_resp;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  logic [32:0] rq[$], exp_r;
  logic fq[$];
  logic [31:0] pts[8] = '{32'h1fff, 32'h2000, 32'h4fff, 32'h5000,
    32'h122f_ffff, 32'h1230_0000, 32'h124f_ffff, 32'h1250_0000};
  logic [15:0] evx[4] = '{16'h8000, 16'h4000, 16'h0100, 16'h0100};
  always #20 clk_sys = ~clk_sys;
  bridge_window_secondary_status bridge_window_secondary_status_i (.clk_sys, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cap_write_unlock,
    .ds_event, .fwd_req, .fwd_resp, .irq);
  fwd_event_agent fwd_event_agent_i (.clk_sys, .rst, .cmd_req, .cmd_ev, .fwd_req, .ds_event);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference window decision, empty when base is above limit
  function automatic logic hit(input logic io, input logic [31:0] a);
    if (io) return a[31:16] == 16'h0 && a[15:12] >= io_lo && a[15:12] <= io_hi;
    return a[31:20] >= m_lo && a[31:20] <= m_hi;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; the idle cycle after it keeps psel single-driven per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic fw(input logic io, input logic [31:0] a);
    fq.push_back(hit(io, a));
    cmd_req <= '{1'b1, io, a};
    @(posedge clk_sys);
  endtask
  task automatic ev(input logic [3:0] e);
    cmd_ev <= e;
    @(posedge clk_sys);
    cmd_ev <= 4'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  // sampled mid-cycle so the registered irq has settled
  task automatic chk_irq(input logic e);
    @(negedge clk_sys);
    `CHK("irq", e, irq)
    @(posedge clk_sys);
  endtask
  // result watcher: oldest note against each answer
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      wrap_up();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_r = rq.pop_front();
      `CHK("read", exp_r, {pslverr, prdata})
    end
    if (fwd_resp.valid === 1'b1) begin
      exp_f = fq.pop_front();
      `CHK("forward", exp_f, fwd_resp.forward)
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h070, 33'h0f1);
    rd(12'h074, 33'h001);
    rd(12'h078, 33'h0);
    rd(12'h080, 33'h0fff0);
    rd(12'h088, 33'h0);
    rd(12'h0fc, 33'h1_0000_0000);
    apb(1'b1, 12'h070, 32'h20);
    rd(12'h070, 33'h021);
    cap_write_unlock <= 1'b1;
    apb(1'b1, 12'h070, 32'h20);
    rd(12'h074, 33'h000);
    apb(1'b1, 12'h070, 32'h21);
    cap_write_unlock <= 1'b0;
    apb(1'b1, 12'h074, 32'hffff_ff4f);
    rd(12'h074, 33'h041);
    apb(1'b1, 12'h080, 32'h123f);
    apb(1'b1, 12'h088, 32'h1240);
    rd(12'h080, 33'h1230);
    rd(12'h088, 33'h1240);
    for (int i = 0; i < 8; i++) fw(i < 4, pts[i]);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      fw(seed[31], seed[31] ? {15'h0, seed[16] & seed[17], seed[15:0]} :
        {12'h122 + {10'h0, seed[21:20]}, seed[19:0]});
    end
    // stop requests first: an idle bus must not leave a held request repeating
    cmd_req <= '0;
    apb(1'b1, 12'h080, 32'h1250);
    m_lo = 12'h125;
    fw(1'b0, 32'h1240_0000);
    fw(1'b0, 32'h1250_0000);
    cmd_req <= '0;
    ev(4'hf);
    rd(12'h078, 33'h8000);
    chk_irq(1'b0);
    apb(1'b1, 12'h100, 32'hc100);
    chk_irq(1'b1);
    apb(1'b1, 12'h078, 32'h4100);
    rd(12'h078, 33'h8000);
    apb(1'b1, 12'h078, 32'hffff);
    rd(12'h078, 33'h0);
    chk_irq(1'b0);
    apb(1'b1, 12'h0f8, 32'h3);
    for (int i = 0; i < 4; i++) begin
      ev(4'(1 << i));
      rd(12'h078, {17'h0, evx[i]});
      chk_irq(1'b1);
      apb(1'b1, 12'h078, 32'hffff);
    end
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule // tb
bind bridge_window_secondary_status bridge_window_secondary_status_asserts chk_i (.clk_sys, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ds_event, .fwd_req, .fwd_resp, .irq);
